// ---- hdl/pti_pkg.sv ----
// Shared constants and types of the top-level event and reset block
package pti_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SOFT_RESET   = 8'h18;
	localparam logic [7:0] OFS_TOP_FIRST    = 8'h19;
	localparam logic [7:0] OFS_TOP_SECOND   = 8'h1a;
	localparam logic [7:0] OFS_BUCK_FLAGS   = 8'h1b;
	localparam logic [7:0] OFS_LINEAR_FLAGS = 8'h1c;
	localparam logic [7:0] OFS_TOP_STATUS   = 8'h1d;
	localparam logic [7:0] OFS_REG_CTRL     = 8'h1e;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_SOFT_RESET = 8'h00;
	localparam logic [7:0] RST_TOP_FIRST  = 8'h00;
	localparam logic [7:0] RST_TOP_SECOND = 8'h00;
	localparam logic [7:0] RST_REG_CTRL   = 8'h00;
	localparam logic [2:0] RST_CH_FLAGS   = 3'h0;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_SOFT_RESET = 0;
	localparam int TF_PG_LOSS     = 7;
	localparam int TF_LIN_SUM     = 6;
	localparam int TF_BUCK_SUM    = 5;
	localparam int TF_CLK_CHG     = 4;
	localparam int TF_TSD         = 3;
	localparam int TF_TWARN       = 2;
	localparam int TF_OVP         = 1;
	localparam int TF_IMEAS       = 0;
	localparam logic [7:0] TF_LATCH_MASK = 8'h9f;
	localparam int TS_RESET_REG   = 0;
	localparam int ST_POWER_GOOD_PIN       = 7;
	localparam int ST_CLK_BAD     = 4;
	localparam int ST_TSD         = 3;
	localparam int ST_TWARN       = 2;
	localparam int ST_OVP         = 1;
	localparam int CTRL_GPO_ONE   = 4;
	localparam int CTRL_GPO_TWO   = 5;
	localparam int NUM_REGS       = 4;
	localparam int FB_ILIM        = 0;
	localparam int FB_SC          = 1;
	localparam int FB_PG          = 2;
	localparam int FB_STRIDE      = 4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int SC_TIME_NS    = 1000000;
	localparam int SC_CYCLES     = (SC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SC_CNT_W      = 17;

	// Serial address default, arbitrary
	localparam logic [6:0] DEF_DEV_ADDR = 7'h60;

	typedef enum logic [8:0] {
		SP_IDLE  = 9'h001,
		SP_ADDR  = 9'h002,
		SP_AACK  = 9'h004,
		SP_REG   = 9'h008,
		SP_REGAK = 9'h010,
		SP_WDATA = 9'h020,
		SP_WACK  = 9'h040,
		SP_RDATA = 9'h080,
		SP_RACK  = 9'h100
	} pti_sp_state_t;

endpackage

// ---- hdl/pti_reg_flags.sv ----
// Per-regulator latched event flags with short-circuit hold timer
`timescale 1ns/10ps
module pti_reg_flags
	import pti_pkg::*;
#(
	parameter int N     = 2,
	parameter int HOLD  = SC_CYCLES,
	parameter int CNT_W = SC_CNT_W
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         clr_stb,
	input  wire logic [7:0]   clr_data,
	input  wire logic [N-1:0] pg_evt,
	input  wire logic [N-1:0] sc_low,
	input  wire logic [N-1:0] ilim,
	output logic      [7:0]   flags
);

	localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(HOLD);

	// ----------------------------------------------------------------
	// One flag group per regulator
	// ----------------------------------------------------------------
	for (genvar i = 0; i < N; i++) begin : g_ch
		logic [CNT_W-1:0] tmr;
		logic [CNT_W-1:0] next_tmr;
		logic [2:0]       f;
		logic [2:0]       next_f;
		logic [2:0]       clr;
		logic [2:0]       set;

		always_comb begin
			next_tmr = tmr;
			set      = 3'h0;
			clr      = clr_stb ? clr_data[FB_STRIDE*i +: 3] : 3'h0;
			// Counter saturates so a held short keeps re-asserting the flag
			if (!sc_low[i]) begin
				next_tmr = '0;
			end else if (tmr == HOLD_CNT) begin
				set[FB_SC] = 1'b1;
			end else begin
				next_tmr = tmr + 1'b1;
			end
			set[FB_PG]   = pg_evt[i];
			set[FB_ILIM] = ilim[i];
			next_f       = (f & ~clr) | set;
		end

		always_ff @(posedge clk) begin
			if (!rst_n) begin
				tmr <= '0;
				f   <= RST_CH_FLAGS;
			end else if (ce) begin
				tmr <= next_tmr;
				f   <= next_f;
			end
		end

		assign flags[FB_STRIDE*i +: FB_STRIDE] = {1'b0, f};
	end

endmodule

// ---- hdl/pti_serial_port.sv ----
// Two-wire serial register port, sampled on the system clock
`timescale 1ns/10ps
module pti_serial_port
	import pti_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEF_DEV_ADDR
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       scl,
	input  wire logic       sda_in,
	input  wire logic [7:0] rd_data,
	output logic            sda_out,
	output logic            sda_oe,
	output logic            wr_stb,
	output logic      [7:0] reg_ptr,
	output logic      [7:0] wr_data
);

	pti_sp_state_t state;
	pti_sp_state_t next_state;
	logic [3:0]    cnt;
	logic [3:0]    next_cnt;
	logic [7:0]    sh;
	logic [7:0]    next_sh;
	logic [7:0]    next_ptr;
	logic [7:0]    next_wdata;
	logic          is_rd;
	logic          next_rd;
	logic          nack;
	logic          next_nack;
	logic          next_oe;
	logic          next_wr;
	logic          scl_q;
	logic          sda_q;
	logic          start;
	logic          stop;
	logic          rise;
	logic          fall;

	// ----------------------------------------------------------------
	// Bus conditions
	// ----------------------------------------------------------------
	assign start = scl_q & scl & sda_q & ~sda_in;
	assign stop  = scl_q & scl & ~sda_q & sda_in;
	assign rise  = scl & ~scl_q;
	assign fall  = ~scl & scl_q;

	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_sh    = sh;
		next_ptr   = reg_ptr;
		next_wdata = wr_data;
		next_rd    = is_rd;
		next_nack  = nack;
		next_oe    = sda_oe;
		next_wr    = 1'b0;
		if (start) begin
			next_state = SP_ADDR;
			next_cnt   = 4'h0;
			next_oe    = 1'b0;
		end else if (stop) begin
			next_state = SP_IDLE;
			next_oe    = 1'b0;
		end else if (rise) begin
			if (state == SP_ADDR || state == SP_REG || state == SP_WDATA) begin
				next_sh  = {sh[6:0], sda_in};
				next_cnt = cnt + 4'h1;
			end else if (state == SP_RACK) begin
				next_nack = sda_in;
			end
		end else if (fall) begin
			case (state)
				SP_ADDR: begin
					if (cnt == 4'h8) begin
						if (sh[7:1] == DEV_ADDR) begin
							next_oe    = 1'b1;
							next_rd    = sh[0];
							next_state = SP_AACK;
						end else begin
							next_state = SP_IDLE;
						end
					end
				end
				SP_AACK: begin
					next_cnt = 4'h0;
					if (is_rd) begin
						next_sh    = rd_data;
						next_oe    = ~rd_data[7];
						next_state = SP_RDATA;
					end else begin
						next_oe    = 1'b0;
						next_state = SP_REG;
					end
				end
				SP_REG: begin
					if (cnt == 4'h8) begin
						next_ptr   = sh;
						next_oe    = 1'b1;
						next_state = SP_REGAK;
					end
				end
				SP_REGAK, SP_WACK: begin
					if (state == SP_WACK) begin
						next_ptr = reg_ptr + 8'h01;
					end
					next_oe    = 1'b0;
					next_cnt   = 4'h0;
					next_state = SP_WDATA;
				end
				SP_WDATA: begin
					if (cnt == 4'h8) begin
						next_wr    = 1'b1;
						next_wdata = sh;
						next_oe    = 1'b1;
						next_state = SP_WACK;
					end
				end
				SP_RDATA: begin
					if (cnt == 4'h7) begin
						next_oe    = 1'b0;
						next_ptr   = reg_ptr + 8'h01;
						next_state = SP_RACK;
					end else begin
						next_cnt = cnt + 4'h1;
						next_sh  = {sh[6:0], 1'b0};
						next_oe  = ~sh[6];
					end
				end
				SP_RACK: begin
					if (nack) begin
						next_state = SP_IDLE;
					end else begin
						next_sh    = rd_data;
						next_oe    = ~rd_data[7];
						next_cnt   = 4'h0;
						next_state = SP_RDATA;
					end
				end
				default: begin
					next_state = state;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state   <= SP_IDLE;
			cnt     <= 4'h0;
			sh      <= 8'h00;
			reg_ptr <= 8'h00;
			wr_data <= 8'h00;
			is_rd   <= 1'b0;
			nack    <= 1'b0;
			sda_oe  <= 1'b0;
			sda_out <= 1'b0;
			wr_stb  <= 1'b0;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
		end else if (ce) begin
			state   <= next_state;
			cnt     <= next_cnt;
			sh      <= next_sh;
			reg_ptr <= next_ptr;
			wr_data <= next_wdata;
			is_rd   <= next_rd;
			nack    <= next_nack;
			sda_oe  <= next_oe;
			sda_out <= 1'b0;
			wr_stb  <= next_wr;
			scl_q   <= scl;
			sda_q   <= sda_in;
		end
	end

endmodule

// ---- hdl/pti_top.sv ----
// Top-level event flags, regulator control and software reset
//
// Behaviour
// - Writing 1 to soft reset command resets registers, reloads OTP, resets port.
// - Soft reset command bit clears itself after its reset.
// - Power-good pin going inactive latches bit 7 of first top register.
// - Latched top flags stay set until host writes 1 there.
// - Bit 6 reads 1 while any linear regulator flag is pending.
// - Bit 5 reads 1 while any buck regulator flag is pending.
// - External clock appearing or disappearing latches bit 4.
// - Thermal shutdown latches bit 3, disables regulators, drives outputs low.
// - While thermal shutdown flag is set, regulator enable requests are refused.
// - Thermal warning latches bit 2; regulators keep running.
// - Live thermal and overvoltage status read separately from latched flags.
// - Input overvoltage latches bit 1, disables regulators, drives outputs low.
// - New load-current measurement result latches bit 0.
// - Undervoltage or soft reset latches bit 0 of second top register.
// - After undervoltage or soft reset: regulators off, defaults, startup again.
// - Reserved bits of reset and second top registers reset to zero.
// - Buck regulators have power-good, held short and current-limit W1C flags.
// - Linear regulators have power-good, held short and current-limit W1C flags.
`timescale 1ns/10ps
module pti_top
	import pti_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR  = DEF_DEV_ADDR,
	parameter int          SC_HOLD  = SC_CYCLES,
	parameter int          NUM_BUCK = 2,
	parameter int          NUM_LIN  = 2
) (
	input  wire logic                CLK,
	input  wire logic                RESET_N,
	input  wire logic                CE,
	input  wire logic                SCL,
	input  wire logic                SDA_IN,
	output logic                     SDA_OUT,
	output logic                     SDA_OE,
	input  wire logic                POWER_GOOD_PIN,
	input  wire logic                EXT_CLK_PRESENT,
	input  wire logic                THERMAL_SHUTDOWN,
	input  wire logic                THERMAL_WARNING,
	input  wire logic                INPUT_OVERVOLTAGE,
	input  wire logic                LOAD_MEAS_DONE,
	input  wire logic                ANALOG_SUPPLY_LOW,
	input  wire logic [NUM_BUCK-1:0] BUCK_PG_EVENT,
	input  wire logic [NUM_BUCK-1:0] BUCK_SC_LOW,
	input  wire logic [NUM_BUCK-1:0] BUCK_ILIM,
	input  wire logic [NUM_LIN-1:0]  LINEAR_PG_EVENT,
	input  wire logic [NUM_LIN-1:0]  LINEAR_SC_LOW,
	input  wire logic [NUM_LIN-1:0]  LINEAR_ILIM,
	output logic      [NUM_REGS-1:0] REG_ENABLE,
	output logic                     GENERAL_OUTPUT_ONE,
	output logic                     GENERAL_OUTPUT_TWO,
	output logic                     IRQ,
	output logic                     OTP_RELOAD,
	output logic                     STARTUP_REQ
);

	// ----------------------------------------------------------------
	// Internal reset
	// ----------------------------------------------------------------
	logic       soft_reset_cmd;
	logic       next_soft_reset_cmd;
	logic       rst_int;
	logic       live_rst_n;
	logic       rst_q;
	logic       next_otp;
	logic       next_startup;

	// Undervoltage holds the logic in reset for as long as it lasts
	assign rst_int    = soft_reset_cmd | ANALOG_SUPPLY_LOW;
	assign live_rst_n = RESET_N & ~rst_int;

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	logic       wr_stb;
	logic [7:0] reg_ptr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;

	// Port is reset with the registers so a half-done transfer is dropped
	pti_serial_port #(
		.DEV_ADDR (DEV_ADDR)
	) u_port (
		.clk      (CLK),
		.rst_n    (live_rst_n),
		.ce       (CE),
		.scl      (SCL),
		.sda_in   (SDA_IN),
		.rd_data  (rd_data),
		.sda_out  (SDA_OUT),
		.sda_oe   (SDA_OE),
		.wr_stb   (wr_stb),
		.reg_ptr  (reg_ptr),
		.wr_data  (wr_data)
	);

	// ----------------------------------------------------------------
	// Regulator flag banks
	// ----------------------------------------------------------------
	logic [7:0] buck_flags;
	logic [7:0] lin_flags;
	logic       wr_buck;
	logic       wr_lin;

	assign wr_buck = wr_stb && (reg_ptr == OFS_BUCK_FLAGS);
	assign wr_lin  = wr_stb && (reg_ptr == OFS_LINEAR_FLAGS);

	pti_reg_flags #(
		.N     (NUM_BUCK),
		.HOLD  (SC_HOLD),
		.CNT_W (SC_CNT_W)
	) u_buck (
		.clk      (CLK),
		.rst_n    (live_rst_n),
		.ce       (CE),
		.clr_stb  (wr_buck),
		.clr_data (wr_data),
		.pg_evt   (BUCK_PG_EVENT),
		.sc_low   (BUCK_SC_LOW),
		.ilim     (BUCK_ILIM),
		.flags    (buck_flags)
	);

	pti_reg_flags #(
		.N     (NUM_LIN),
		.HOLD  (SC_HOLD),
		.CNT_W (SC_CNT_W)
	) u_lin (
		.clk      (CLK),
		.rst_n    (live_rst_n),
		.ce       (CE),
		.clr_stb  (wr_lin),
		.clr_data (wr_data),
		.pg_evt   (LINEAR_PG_EVENT),
		.sc_low   (LINEAR_SC_LOW),
		.ilim     (LINEAR_ILIM),
		.flags    (lin_flags)
	);

	// ----------------------------------------------------------------
	// Event detection and top flags
	// ----------------------------------------------------------------
	logic [7:0]          top_first;
	logic [7:0]          next_top_first;
	logic [7:0]          top_second;
	logic [7:0]          next_top_second;
	logic [7:0]          reg_ctrl;
	logic [7:0]          next_reg_ctrl;
	logic [7:0]          ev;
	logic [7:0]          clr_first;
	logic [7:0]          clr_second;
	logic [NUM_REGS-1:0] req_en;
	logic                lin_pending;
	logic                buck_pending;
	logic                trip;
	logic                next_irq;
	logic                pg_q;
	logic                clk_q;
	logic                tsd_q;
	logic                twarn_q;
	logic                ovp_q;

	assign lin_pending  = |lin_flags;
	assign buck_pending = |buck_flags;

	always_comb begin
		ev              = 8'h00;
		ev[TF_PG_LOSS]  = pg_q & ~POWER_GOOD_PIN;
		ev[TF_CLK_CHG]  = clk_q ^ EXT_CLK_PRESENT;
		ev[TF_TSD]      = THERMAL_SHUTDOWN & ~tsd_q;
		ev[TF_TWARN]    = THERMAL_WARNING & ~twarn_q;
		ev[TF_OVP]      = INPUT_OVERVOLTAGE & ~ovp_q;
		ev[TF_IMEAS]    = LOAD_MEAS_DONE;
		trip            = ev[TF_TSD] | ev[TF_OVP];
		clr_first       = 8'h00;
		clr_second      = 8'h00;
		next_reg_ctrl   = reg_ctrl;
		next_soft_reset_cmd = soft_reset_cmd;
		req_en          = reg_ctrl[NUM_REGS-1:0];
		if (wr_stb) begin
			if (reg_ptr == OFS_TOP_FIRST) begin
				clr_first = wr_data & TF_LATCH_MASK;
			end else if (reg_ptr == OFS_TOP_SECOND) begin
				clr_second[TS_RESET_REG] = wr_data[TS_RESET_REG];
			end else if (reg_ptr == OFS_SOFT_RESET) begin
				next_soft_reset_cmd = wr_data[BIT_SOFT_RESET];
			end else if (reg_ptr == OFS_REG_CTRL) begin
				req_en = wr_data[NUM_REGS-1:0];
				// Switching off is always allowed, switching on is not
				if (top_first[TF_TSD]) begin
					req_en = req_en & reg_ctrl[NUM_REGS-1:0];
				end
				next_reg_ctrl = wr_data;
				next_reg_ctrl[NUM_REGS-1:0] = req_en;
				next_reg_ctrl[7:6] = 2'b00;
			end
		end
		if (trip) begin
			next_reg_ctrl = RST_REG_CTRL;
		end
		// Set wins over a clear landing in the same cycle
		next_top_first = ((top_first & ~clr_first) | ev) & TF_LATCH_MASK;
		next_top_second = (top_second & ~clr_second);
		next_top_second[TS_RESET_REG] = next_top_second[TS_RESET_REG] | rst_int;
		next_irq = (|top_first) | lin_pending | buck_pending | top_second[TS_RESET_REG];
		next_otp = rst_int & ~rst_q;
		next_startup = rst_q & ~rst_int;
	end

	// ----------------------------------------------------------------
	// Registers cleared by either reset
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!live_rst_n) begin
			soft_reset_cmd <= RST_SOFT_RESET[BIT_SOFT_RESET];
			top_first      <= RST_TOP_FIRST;
			reg_ctrl       <= RST_REG_CTRL;
			IRQ            <= 1'b0;
			pg_q           <= 1'b0;
			clk_q          <= 1'b0;
			tsd_q          <= 1'b0;
			twarn_q        <= 1'b0;
			ovp_q          <= 1'b0;
		end else if (CE) begin
			soft_reset_cmd <= next_soft_reset_cmd;
			top_first      <= next_top_first;
			reg_ctrl       <= next_reg_ctrl;
			IRQ            <= next_irq;
			pg_q           <= POWER_GOOD_PIN;
			clk_q          <= EXT_CLK_PRESENT;
			tsd_q          <= THERMAL_SHUTDOWN;
			twarn_q        <= THERMAL_WARNING;
			ovp_q          <= INPUT_OVERVOLTAGE;
		end
	end

	// ----------------------------------------------------------------
	// Registers that must survive the internal reset
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			top_second  <= RST_TOP_SECOND;
			rst_q       <= 1'b0;
			OTP_RELOAD  <= 1'b0;
			STARTUP_REQ <= 1'b0;
		end else if (CE) begin
			top_second  <= next_top_second;
			rst_q       <= rst_int;
			OTP_RELOAD  <= next_otp;
			STARTUP_REQ <= next_startup;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign REG_ENABLE         = reg_ctrl[NUM_REGS-1:0];
	assign GENERAL_OUTPUT_ONE = reg_ctrl[CTRL_GPO_ONE];
	assign GENERAL_OUTPUT_TWO = reg_ctrl[CTRL_GPO_TWO];

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 8'h00;
		if (reg_ptr == OFS_SOFT_RESET) begin
			rd_data[BIT_SOFT_RESET] = soft_reset_cmd;
		end else if (reg_ptr == OFS_TOP_FIRST) begin
			rd_data              = top_first;
			rd_data[TF_LIN_SUM]  = lin_pending;
			rd_data[TF_BUCK_SUM] = buck_pending;
		end else if (reg_ptr == OFS_TOP_SECOND) begin
			rd_data = top_second;
		end else if (reg_ptr == OFS_BUCK_FLAGS) begin
			rd_data = buck_flags;
		end else if (reg_ptr == OFS_LINEAR_FLAGS) begin
			rd_data = lin_flags;
		end else if (reg_ptr == OFS_TOP_STATUS) begin
			rd_data[ST_POWER_GOOD_PIN]   = POWER_GOOD_PIN;
			rd_data[ST_CLK_BAD] = ~EXT_CLK_PRESENT;
			rd_data[ST_TSD]     = THERMAL_SHUTDOWN;
			rd_data[ST_TWARN]   = THERMAL_WARNING;
			rd_data[ST_OVP]     = INPUT_OVERVOLTAGE;
		end else if (reg_ptr == OFS_REG_CTRL) begin
			rd_data = reg_ctrl;
		end
	end

endmodule

// ---- verif/pti_host_model.sv ----
// Serial host model on a pulled-up two-wire line
`timescale 1ns/10ps
module pti_host_model
	import pti_pkg::*;
(
	input  wire logic clk,
	input  wire logic dev_oe,
	output logic      scl,
	output logic      sda
);
	logic lo = 1'b0;
	// Pull-up: a released line reads high, never the last bit driven
	assign sda = ~(lo | dev_oe);
	initial scl = 1'b1;
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Four clocks a phase keeps the port's three-clock minimum
	task automatic bit_io(input logic b, output logic s);
		lo <= ~b;
		tick(4);
		scl <= 1'b1;
		tick(4);
		s = sda;
		scl <= 1'b0;
		tick(1);
	endtask
	task automatic cond(input logic a, input logic b);
		lo <= a;
		tick(4);
		scl <= 1'b1;
		tick(4);
		lo <= b;
		tick(4);
	endtask
	task automatic start();
		cond(1'b0, 1'b1);
		scl <= 1'b0;
		tick(4);
	endtask
	task automatic byte_io(input logic [7:0] d, input logic m,
		output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(m, a);
	endtask
	task automatic wr(input logic [6:0] dev, input logic [7:0] r,
		input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic [2:0] a;
		start();
		byte_io({dev, 1'b0}, 1'b1, q, a[0]);
		byte_io(r, 1'b1, q, a[1]);
		byte_io(d, 1'b1, q, a[2]);
		cond(1'b1, 1'b0);
		ok = (a == 3'h0);
	endtask
	// Pointer write, repeated start, one byte, or two when the first is acknowledged
	task automatic rd(input logic [7:0] r, input logic m, output logic [15:0] d);
		logic [7:0] q;
		logic a;
		start();
		byte_io({DEF_DEV_ADDR, 1'b0}, 1'b1, q, a);
		byte_io(r, 1'b1, q, a);
		start();
		byte_io({DEF_DEV_ADDR, 1'b1}, 1'b1, q, a);
		byte_io(8'hff, m, d[15:8], a);
		if (!m)
			byte_io(8'hff, 1'b1, d[7:0], a);
		cond(1'b1, 1'b0);
	endtask
endmodule

// ---- verif/pti_top_monitor.sv ----
// Port checks of the event and reset block
`timescale 1ns/10ps
module pti_top_monitor
	import pti_pkg::*;
(
	input wire logic                CLK,
	input wire logic                RESET_N,
	input wire logic                SDA_OUT,
	input wire logic                SDA_OE,
	input wire logic                THERMAL_SHUTDOWN,
	input wire logic                INPUT_OVERVOLTAGE,
	input wire logic                ANALOG_SUPPLY_LOW,
	input wire logic [NUM_REGS-1:0] REG_ENABLE,
	input wire logic                GENERAL_OUTPUT_ONE,
	input wire logic                GENERAL_OUTPUT_TWO,
	input wire logic                OTP_RELOAD,
	input wire logic                STARTUP_REQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	wire logic quiet = (REG_ENABLE == '0) && !GENERAL_OUTPUT_ONE && !GENERAL_OUTPUT_TWO;
	tsd_off_a: assert property ($rose(THERMAL_SHUTDOWN) |-> ##[1:2] quiet)
		else $error("outputs on after thermal shutdown");
	ovp_off_a: assert property ($rose(INPUT_OVERVOLTAGE) |-> ##[1:2] quiet)
		else $error("outputs on after overvoltage");
	uv_off_a: assert property (ANALOG_SUPPLY_LOW [*3] |-> quiet)
		else $error("outputs on during undervoltage");
	uv_reload_a: assert property ($rose(ANALOG_SUPPLY_LOW) |-> ##[1:3] OTP_RELOAD)
		else $error("no reload after undervoltage");
	uv_startup_a: assert property ($fell(ANALOG_SUPPLY_LOW) |-> ##[1:3] STARTUP_REQ)
		else $error("no startup after undervoltage");
	reload_pulse_a: assert property (OTP_RELOAD |-> !$past(OTP_RELOAD))
		else $error("reload longer than one cycle");
	startup_pulse_a: assert property (STARTUP_REQ |=> !STARTUP_REQ)
		else $error("startup longer than one cycle");
	reload_clean_a: assert property (OTP_RELOAD |-> quiet && !SDA_OE)
		else $error("state not cleared at reload");
	sda_low_a: assert property (SDA_OE |-> !SDA_OUT)
		else $error("data line driven high");
	tsd_c: cover property ($rose(THERMAL_SHUTDOWN));
	soft_c: cover property (OTP_RELOAD && !ANALOG_SUPPLY_LOW);
	ack_c: cover property ($rose(SDA_OE));
endmodule
bind pti_top pti_top_monitor u_mon (.CLK, .RESET_N, .SDA_OUT, .SDA_OE,
	.THERMAL_SHUTDOWN, .INPUT_OVERVOLTAGE, .ANALOG_SUPPLY_LOW, .REG_ENABLE,
	.GENERAL_OUTPUT_ONE, .GENERAL_OUTPUT_TWO, .OTP_RELOAD, .STARTUP_REQ);

// ---- verif/pmic_top_interrupt_reset_tb.sv ----
// Self-checking bench of the event and reset block
`timescale 1ns/10ps
module pmic_top_interrupt_reset_tb
	import pti_pkg::*;
;
	// Short hold keeps the short-circuit cases brief
	localparam int HOLD = 10;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        pg = 1'b1;
	logic        ext = 1'b0;
	logic        tsd = 1'b0;
	logic        twarn = 1'b0;
	logic        ovp = 1'b0;
	logic        meas = 1'b0;
	logic        uv = 1'b0;
	logic        ce = 1'b1;
	logic [11:0] chv = '0;
	logic        scl, sda, sda_oe, gpo1, general_output_two, irq, otp, st;
	logic [3:0]  en;
	int          err_total = 0;
	int          samples_checked = 0;
	int          otp_n = 0;
	int          st_n = 0;
	int          bitpos [6] = '{TF_PG_LOSS, TF_CLK_CHG, TF_TSD, TF_TWARN, TF_OVP, TF_IMEAS};
	initial begin
		forever #4 clk = ~clk;
	end
	pti_top #(.SC_HOLD(HOLD)) u_dut (.CLK(clk), .RESET_N(rst_n), .CE(ce), .SCL(scl),
		.SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .POWER_GOOD_PIN(pg),
		.EXT_CLK_PRESENT(ext), .THERMAL_SHUTDOWN(tsd), .THERMAL_WARNING(twarn),
		.INPUT_OVERVOLTAGE(ovp), .LOAD_MEAS_DONE(meas), .ANALOG_SUPPLY_LOW(uv),
		.BUCK_ILIM(chv[1:0]), .BUCK_SC_LOW(chv[3:2]), .BUCK_PG_EVENT(chv[5:4]),
		.LINEAR_ILIM(chv[7:6]), .LINEAR_SC_LOW(chv[9:8]), .LINEAR_PG_EVENT(chv[11:10]),
		.REG_ENABLE(en), .GENERAL_OUTPUT_ONE(gpo1), .GENERAL_OUTPUT_TWO(general_output_two),
		.IRQ(irq), .OTP_RELOAD(otp), .STARTUP_REQ(st));
	pti_host_model u_host (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
	always @(posedge clk) begin
		if (otp === 1'b1)
			otp_n <= otp_n + 1;
		if (st === 1'b1)
			st_n <= st_n + 1;
	end
	function automatic logic [7:0] stat_exp();
		return {pg, 2'h0, ~ext, tsd, twarn, ovp, 1'b0};
	endfunction
	function automatic logic [7:0] ch_bit(input int i, input int k);
		return 8'h01 << (4 * i + k);
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [7:0] r, input logic [7:0] e);
		logic [15:0] q;
		u_host.rd(r, 1'b1, q);
		chk($sformatf("reg %h", r), e, q[15:8]);
	endtask
	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		logic ok;
		u_host.wr(DEF_DEV_ADDR, r, d, ok);
	endtask
	// Sampled at the falling edge so the outputs have settled
	task automatic pchk(input logic [7:0] e);
		@(negedge clk);
		chk("pins", e, {1'b0, irq, general_output_two, gpo1, en});
		@(posedge clk);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Run needs about 42000 cycles; the limit leaves more than twice that
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		final_report();
	end
	initial begin
		logic [7:0] v, b, o, s, keep;
		logic [15:0] w;
		logic       ok;
		int         k, j;
		void'($urandom(32'h499f));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rchk(OFS_SOFT_RESET, RST_SOFT_RESET);
		rchk(OFS_TOP_FIRST, RST_TOP_FIRST);
		rchk(OFS_TOP_SECOND, RST_TOP_SECOND);
		rchk(OFS_REG_CTRL, RST_REG_CTRL);
		rchk(8'h30, 8'h00);
		u_host.wr(7'h21, OFS_REG_CTRL, 8'h0f, ok);
		chk("ack", 8'h00, {7'h0, ok});
		pchk(8'h00);
		// A pulse while the clock enable is low must leave no trace
		ce <= 1'b0;
		meas <= 1'b1;
		@(posedge clk);
		ce <= 1'b1;
		meas <= 1'b0;
		rchk(OFS_TOP_FIRST, 8'h00);
		for (k = 0; k < 6; k++) begin
			v = {2'h0, 6'($urandom()) | 6'h01};
			wr(OFS_REG_CTRL, v);
			case (k)
				0: pg <= 1'b0;
				1: ext <= 1'b1;
				2: tsd <= 1'b1;
				3: twarn <= 1'b1;
				4: ovp <= 1'b1;
				default: meas <= 1'b1;
			endcase
			@(posedge clk);
			meas <= 1'b0;
			repeat (4) @(posedge clk);
			b = 8'h01 << bitpos[k];
			keep = (k == 2 || k == 4) ? 8'h00 : v;
			pchk(8'h40 | keep);
			rchk(OFS_TOP_FIRST, b);
			rchk(OFS_TOP_STATUS, stat_exp());
			if (k == 2) begin
				wr(OFS_REG_CTRL, 8'h0f);
				rchk(OFS_REG_CTRL, 8'h00);
			end
			wr(OFS_TOP_FIRST, ~b & TF_LATCH_MASK);
			rchk(OFS_TOP_FIRST, b);
			wr(OFS_TOP_FIRST, b);
			rchk(OFS_TOP_FIRST, 8'h00);
			pchk(keep);
			tsd <= 1'b0;
			twarn <= 1'b0;
			ovp <= 1'b0;
		end
		// Index: bank, then kind (limit, short, good), then channel
		for (j = 0; j < 12; j++) begin
			o = (j < 6) ? OFS_BUCK_FLAGS : OFS_LINEAR_FLAGS;
			s = 8'h01 << ((j < 6) ? TF_BUCK_SUM : TF_LIN_SUM);
			b = ch_bit(j % 2, (j % 6) / 2);
			chv[j] <= 1'b1;
			repeat (3 * HOLD) @(posedge clk);
			chv[j] <= 1'b0;
			repeat (2) @(posedge clk);
			rchk(o, b);
			rchk(OFS_TOP_FIRST, s);
			pchk(8'h40 | keep);
			wr(o, b);
			rchk(o, 8'h00);
			rchk(OFS_TOP_FIRST, 8'h00);
		end
		wr(OFS_REG_CTRL, 8'h3f);
		wr(OFS_SOFT_RESET, 8'h01);
		repeat (4) @(posedge clk);
		pchk(8'h40);
		chk("reloads", 8'h01, 8'(otp_n));
		chk("startups", 8'h01, 8'(st_n));
		rchk(OFS_SOFT_RESET, 8'h00);
		// Clock still present re-latches once the edge detector is cleared
		rchk(OFS_TOP_FIRST, 8'h01 << TF_CLK_CHG);
		rchk(OFS_REG_CTRL, 8'h00);
		rchk(OFS_TOP_SECOND, 8'h01);
		// Two-byte read steps the pointer from the first to the second top register
		u_host.rd(OFS_TOP_FIRST, 1'b0, w);
		chk("burst", 8'h01, w[7:0]);
		wr(OFS_TOP_SECOND, 8'h01);
		rchk(OFS_TOP_SECOND, 8'h00);
		uv <= 1'b1;
		repeat (6) @(posedge clk);
		uv <= 1'b0;
		repeat (4) @(posedge clk);
		chk("reloads", 8'h02, 8'(otp_n));
		rchk(OFS_TOP_SECOND, 8'h01);
		final_report();
	end
endmodule
